/* File: rtl/ivp_apb_slave.sv */
// APB slave front end: one wait state, registered answer.
// Assumes an APB master that holds the request until pready is seen.
`timescale 1ns/1ps
module ivp_apb_slave
    import ivp_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk_i,
    input  wire logic               resetn_i,
    // APB
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [PADDR_W-1:0] paddr_i,
    input  wire logic [31:0]        pwdata_i,
    output logic                    pready_o,
    output logic [31:0]             prdata_o,
    output logic                    pslverr_o,
    // Register side
    ivp_reg_if.bus                  regs
);

    // Access phase seen, answer not yet given
    wire access_wait = psel_i && penable_i && !pready_o;
    // Completing edge of a transfer
    wire access_done = psel_i && penable_i && pready_o;

    // Writes act only at the completing edge
    assign regs.wr_stb = access_done && pwrite_i && regs.hit;
    assign regs.addr   = paddr_i;
    assign regs.wdata  = pwdata_i;

    // Answer one cycle into the access phase; read data frozen with it
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h00000000;
            pslverr_o <= 1'b0;
        end
        else if (access_wait)
        begin
            pready_o  <= 1'b1;
            prdata_o  <= (!pwrite_i && regs.hit) ? regs.rdata : 32'h00000000;
            pslverr_o <= !regs.hit; // Unmapped address
        end
        else
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

endmodule : ivp_apb_slave

/* File: rtl/ivp_pkg.sv */
// Package for the interrupt vector placement block: register map, field
// positions, reset values, vector offsets, state encodings and helpers.
// Assumes a 16-bit word address space on the core side and 32-bit APB data.
package ivp_pkg;

    // Sizes
    localparam int          NUM_SRC       = 24; // Interrupt sources
    localparam int          IDX_W         = 5; // Source index width
    localparam int          ADDR_W        = 16; // Core word address
    localparam int          PADDR_W       = 12; // APB address width

    // Register byte offsets
    localparam logic [11:0] REG_CTRL      = 12'h000; // core_control_register
    localparam logic [11:0] REG_ENABLE    = 12'h004; // Per-source enables
    localparam logic [11:0] REG_PEND      = 12'h008; // Enabled and requesting
    localparam logic [11:0] REG_STATUS    = 12'h00c; // Dispatch state

    // Field positions
    localparam int          CTRL_CE_BIT   = 0; // vector_change_enable
    localparam int          CTRL_SEL_BIT  = 1; // vector_base_select
    localparam int          ST_IRQ_BIT    = 0; // Request to core active
    localparam int          ST_BLK_BIT    = 1; // Dispatch blocked
    localparam int          ST_FUSE_BIT   = 2; // Fuse level seen
    localparam int          ST_IDX_LSB    = 8; // Index of last vector

    // Reset values
    localparam logic [23:0] ENABLE_RST    = 24'h000000;
    localparam logic        SEL_RST       = 1'b0;
    localparam logic [15:0] ADDR_RST      = 16'h0000;

    // Fuse encoding
    localparam logic        FUSE_PROGRAMMED = 1'b0; // Start in boot section

    // Reset and vector offsets (word addresses)
    localparam logic [15:0] RESET_ADDR_APP = 16'h0000;
    localparam logic [15:0] VEC_EXT0       = 16'h0002;
    localparam logic [15:0] VEC_PCG0       = 16'h0004;
    localparam logic [15:0] VEC_PCG1       = 16'h0006;
    localparam logic [15:0] VEC_WDOG       = 16'h0008;
    localparam logic [15:0] VEC_WAKE       = 16'h000a;
    localparam logic [15:0] VEC_T1_IC      = 16'h000c;
    localparam logic [15:0] VEC_T1_CA      = 16'h000e;
    localparam logic [15:0] VEC_T1_CB      = 16'h0010;
    localparam logic [15:0] VEC_T1_OVF     = 16'h0012;
    localparam logic [15:0] VEC_T0_IC      = 16'h0014;
    localparam logic [15:0] VEC_T0_CA      = 16'h0016;
    localparam logic [15:0] VEC_T0_CB      = 16'h0018;
    localparam logic [15:0] VEC_T0_OVF     = 16'h001a;
    localparam logic [15:0] VEC_LIN_ST     = 16'h001c;
    localparam logic [15:0] VEC_LIN_ERR    = 16'h001e;
    localparam logic [15:0] VEC_SER_TC     = 16'h0020;
    localparam logic [15:0] VEC_VC_CONV    = 16'h0022;
    localparam logic [15:0] VEC_VC_ACC     = 16'h0024;
    localparam logic [15:0] VEC_CC_CONV    = 16'h0026;
    localparam logic [15:0] VEC_CC_REG     = 16'h0028;
    localparam logic [15:0] VEC_CC_ACC     = 16'h002a;
    localparam logic [15:0] VEC_NVM_RDY    = 16'h002c;
    localparam logic [15:0] VEC_PST_RDY    = 16'h002e;
    localparam logic [15:0] VEC_CLK_LOCK   = 16'h0030;

    // Timing: select write must follow change enable within this many cycles
    localparam logic [2:0]  CHG_WINDOW_CYC = 3'd4;

    // Change sequence states
    typedef enum logic [1:0] {
        CHG_IDLE  = 2'b00, // Normal operation
        CHG_ARMED = 2'b01, // Change enable open
        CHG_HOLD  = 2'b10 // Wait one instruction
    } ivp_chg_t;

    // Dispatch states
    typedef enum logic {
        DSP_IDLE = 1'b0, // No vector offered
        DSP_WAIT = 1'b1 // Waiting for core to take
    } ivp_dsp_t;

    // Table offset of a source, in source index order
    function automatic logic [15:0] ivp_vec_offset(input logic [4:0] idx);
        logic [15:0] ofs;
        ofs = VEC_EXT0;
        unique case (idx)
            5'h00: ofs = VEC_EXT0; // RL4
            5'h01: ofs = VEC_PCG0; // RL4
            5'h02: ofs = VEC_PCG1; // RL4
            5'h03: ofs = VEC_WDOG; // RL5
            5'h04: ofs = VEC_WAKE; // RL5
            5'h05: ofs = VEC_T1_IC; // RL6
            5'h06: ofs = VEC_T1_CA; // RL6
            5'h07: ofs = VEC_T1_CB; // RL6
            5'h08: ofs = VEC_T1_OVF; // RL6
            5'h09: ofs = VEC_T0_IC; // RL7
            5'h0a: ofs = VEC_T0_CA; // RL7
            5'h0b: ofs = VEC_T0_CB; // RL7
            5'h0c: ofs = VEC_T0_OVF; // RL7
            5'h0d: ofs = VEC_LIN_ST; // RL8
            5'h0e: ofs = VEC_LIN_ERR; // RL8
            5'h0f: ofs = VEC_SER_TC; // RL8
            5'h10: ofs = VEC_VC_CONV; // RL9
            5'h11: ofs = VEC_VC_ACC; // RL9
            5'h12: ofs = VEC_CC_CONV; // RL10
            5'h13: ofs = VEC_CC_REG; // RL10
            5'h14: ofs = VEC_CC_ACC; // RL10
            5'h15: ofs = VEC_NVM_RDY; // RL11
            5'h16: ofs = VEC_PST_RDY; // RL11
            5'h17: ofs = VEC_CLK_LOCK; // RL11
            default: ofs = VEC_EXT0; // Codes above 23 are illegal
        endcase
        return ofs;
    endfunction : ivp_vec_offset

endpackage : ivp_pkg

/* File: rtl/ivp_prio_enc.sv */
// Finds the lowest-numbered pending source; registered result.
// Assumes pending bits are levels held until the source is serviced.
`timescale 1ns/1ps
module ivp_prio_enc
    import ivp_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk_i,
    input  wire logic               resetn_i,
    // Pending vector in, winner out
    input  wire logic [NUM_SRC-1:0] pend_i,
    output logic                    any_o,
    output logic [IDX_W-1:0]        idx_o
);

    logic [IDX_W-1:0] win_idx; // Combinational winner

    // Scan from the top so the lowest index is left standing
    always_comb
    begin
        win_idx = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (pend_i[i])
                win_idx = IDX_W'(i); // RL16
        end
    end

    // Register the result to keep the adder path short
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            any_o <= 1'b0;
            idx_o <= '0;
        end
        else
        begin
            any_o <= |pend_i;
            idx_o <= win_idx;
        end
    end

endmodule : ivp_prio_enc

/* File: rtl/ivp_reg_if.sv */
// Interface between the APB slave and the register file of the block.
// Assumes both ends run on the same clock; strobes are one cycle wide.
`timescale 1ns/1ps
interface ivp_reg_if;
    import ivp_pkg::*;
    logic               wr_stb; // Write takes effect now
    logic [PADDR_W-1:0] addr; // Byte address
    logic [31:0]        wdata; // Write data
    logic [31:0]        rdata; // Read data for addr
    logic               hit; // addr is mapped

    modport bus  (output wr_stb, output addr, output wdata, input rdata, input hit);
    modport regs (input wr_stb, input addr, input wdata, output rdata, output hit);
endinterface : ivp_reg_if

/* File: rtl/ivp_top.sv */
// Interrupt vector placement: reset address, vector address generation,
// vector table relocation with guarded change sequence, APB registers.
// Assumes the core reports instruction retirement and takes vectors by ack.
//
// Operation
// RL1 - Reset address follows boot-reset fuse
// RL2 - Select set: vector equals offset plus boot start
// RL3 - Fuse one is normal, zero is boot
// RL4 - External irq zero, pin groups at 2,4,6
// RL5 - Watchdog at 8, wake-up at 0xA
// RL6 - Timer1 slots 0xC through 0x12
// RL7 - Timer0 slots 0x14 through 0x1A
// RL8 - LIN status, error, serial complete slots
// RL9 - Voltage converter slots 0x22, 0x24
// RL10 - Current converter slots 0x26 to 0x2A
// RL11 - Memory ready, store ready, lock slots
// RL12 - Vector offered only for enabled sources
// RL13 - Select clear: vectors at flash start
// RL14 - Select changes only within change window
// RL15 - Dispatch blocked during change sequence
// RL16 - Lowest pending offset served first
`timescale 1ns/1ps
module ivp_top
    import ivp_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk_i,
    input  wire logic               resetn_i,
    // APB
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [PADDR_W-1:0] paddr_i,
    input  wire logic [31:0]        pwdata_i,
    output logic                    pready_o,
    output logic [31:0]             prdata_o,
    output logic                    pslverr_o,
    // Configuration
    input  wire logic               boot_reset_fuse_i,
    input  wire logic [ADDR_W-1:0]  boot_start_i,
    // Interrupt sources
    input  wire logic [NUM_SRC-1:0] irq_req_i,
    // Core side
    input  wire logic               global_ie_i,
    input  wire logic               insn_done_i,
    input  wire logic               vec_ack_i,
    output logic [ADDR_W-1:0]       reset_addr_o,
    output logic                    irq_o,
    output logic [ADDR_W-1:0]       vec_addr_o
);

    // Register state
    logic [NUM_SRC-1:0] src_enable; // Per-source enables
    logic               vector_base_select; // Table in boot section
    logic [IDX_W-1:0]   last_idx; // Source last offered
    logic               fuse_seen; // Fuse level after reset

    // Change sequence state
    ivp_chg_t           chg_state;
    ivp_chg_t           next_chg_state;
    logic [2:0]         chg_cnt; // Cycles left in window
    logic [2:0]         next_chg_cnt;
    logic               next_select;

    // Dispatch state
    ivp_dsp_t           dsp_state;
    ivp_dsp_t           next_dsp_state;

    // Priority encoder result
    logic               enc_any;
    logic [IDX_W-1:0]   enc_idx;

    // Register bus carrier
    ivp_reg_if          reg_bus ();

    // APB front end
    ivp_apb_slave u_apb (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .psel_i     (psel_i),
        .penable_i  (penable_i),
        .pwrite_i   (pwrite_i),
        .paddr_i    (paddr_i),
        .pwdata_i   (pwdata_i),
        .pready_o   (pready_o),
        .prdata_o   (prdata_o),
        .pslverr_o  (pslverr_o),
        .regs       (reg_bus.bus)
    );

    // Only enabled sources ever reach the encoder
    wire [NUM_SRC-1:0] pending = irq_req_i & src_enable; // RL12

    // Lowest index wins
    ivp_prio_enc u_enc (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .pend_i     (pending),
        .any_o      (enc_any),
        .idx_o      (enc_idx)
    );

    // Address decode
    wire sel_ctrl   = (reg_bus.addr == REG_CTRL);
    wire sel_enable = (reg_bus.addr == REG_ENABLE);
    wire sel_pend   = (reg_bus.addr == REG_PEND);
    wire sel_status = (reg_bus.addr == REG_STATUS);
    assign reg_bus.hit = sel_ctrl || sel_enable || sel_pend || sel_status;

    // Write strobes; pending and status are read-only, writes there are dropped
    wire wr_ctrl   = reg_bus.wr_stb && sel_ctrl;
    wire wr_enable = reg_bus.wr_stb && sel_enable;
    wire wr_ce     = reg_bus.wdata[CTRL_CE_BIT];
    wire wr_sel    = reg_bus.wdata[CTRL_SEL_BIT];

    // Change enable reads back as one only while the window is open
    wire change_enable_rd = (chg_state == CHG_ARMED);

    // Dispatch blocked from the very cycle change enable is written
    wire irq_block = (chg_state != CHG_IDLE) || (wr_ctrl && wr_ce); // RL15

    // Read data views
    wire [31:0] ctrl_rd   = {30'h0, vector_base_select, change_enable_rd};
    wire [31:0] enable_rd = {8'h00, src_enable};
    wire [31:0] pend_rd   = {8'h00, pending};
    wire [31:0] status_rd = {19'h0, last_idx, 5'h00, fuse_seen,
                             (chg_state != CHG_IDLE), irq_o};
    assign reg_bus.rdata = sel_ctrl   ? ctrl_rd   :
                           sel_enable ? enable_rd :
                           sel_pend   ? pend_rd   :
                           sel_status ? status_rd : 32'h00000000;

    // Table base: flash start while select is clear, boot start while set
    wire [ADDR_W-1:0] table_base = vector_base_select ? boot_start_i    // RL2
                                                      : RESET_ADDR_APP; // RL13
    wire [ADDR_W-1:0] vec_target = table_base + ivp_vec_offset(enc_idx); // RL2

    // Encoder winner still requesting; guards against a source that dropped
    wire winner_live = enc_any && pending[enc_idx]; // RL12
    wire launch      = winner_live && global_ie_i && !irq_block; // RL15

    // Change sequence next state
    always_comb
    begin
        next_chg_state = chg_state;
        next_chg_cnt   = chg_cnt;
        next_select    = vector_base_select;
        unique case (chg_state)
            CHG_IDLE:
            begin
                // Opening the window; select itself is left alone
                if (wr_ctrl && wr_ce)
                begin
                    next_chg_state = CHG_ARMED; // RL14
                    next_chg_cnt   = CHG_WINDOW_CYC;
                end
            end
            CHG_ARMED:
            begin
                if (wr_ctrl && !wr_ce)
                begin
                    // Select write inside the window takes effect
                    next_select    = wr_sel; // RL14
                    next_chg_state = CHG_HOLD; // RL15
                end
                else if (wr_ctrl && wr_ce)
                begin
                    // Writing change enable again restarts the window
                    next_chg_cnt = CHG_WINDOW_CYC;
                end
                else if (chg_cnt == 3'd1)
                begin
                    // Window expired with no select write
                    next_chg_state = CHG_IDLE; // RL14
                    next_chg_cnt   = 3'd0;
                end
                else
                begin
                    next_chg_cnt = chg_cnt - 3'd1;
                end
            end
            CHG_HOLD:
            begin
                // Blocked until the following instruction has retired
                if (insn_done_i)
                    next_chg_state = CHG_IDLE; // RL15
            end
            default:
            begin
                next_chg_state = CHG_IDLE; // Unused code recovers
                next_chg_cnt   = 3'd0;
            end
        endcase
    end

    // Dispatch next state
    always_comb
    begin
        next_dsp_state = dsp_state;
        unique case (dsp_state)
            DSP_IDLE:
            begin
                if (launch)
                    next_dsp_state = DSP_WAIT;
            end
            DSP_WAIT:
            begin
                if (vec_ack_i)
                    next_dsp_state = DSP_IDLE;
            end
        endcase
    end

    // Change sequence registers
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            chg_state          <= CHG_IDLE;
            chg_cnt            <= 3'd0;
            vector_base_select <= SEL_RST;
        end
        else
        begin
            chg_state          <= next_chg_state;
            chg_cnt            <= next_chg_cnt;
            vector_base_select <= next_select;
        end
    end

    // Source enables; global interrupt flag is never touched here
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            src_enable <= ENABLE_RST;
        else if (wr_enable)
            src_enable <= reg_bus.wdata[NUM_SRC-1:0];
    end

    // Dispatch registers: vector address frozen while offered
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dsp_state  <= DSP_IDLE;
            irq_o      <= 1'b0;
            vec_addr_o <= ADDR_RST;
            last_idx   <= '0;
        end
        else
        begin
            dsp_state <= next_dsp_state;
            irq_o     <= (next_dsp_state == DSP_WAIT);
            if (dsp_state == DSP_IDLE && launch)
            begin
                vec_addr_o <= vec_target; // RL16
                last_idx   <= enc_idx;
            end
        end
    end

    // Reset address: the fuse is sampled after release, not under reset,
    // and again on every edge after, so a strap that settles late is still caught on the next edge
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            reset_addr_o <= ADDR_RST;
            fuse_seen    <= 1'b1;
        end
        else
        begin
            fuse_seen    <= boot_reset_fuse_i;
            reset_addr_o <= (boot_reset_fuse_i == FUSE_PROGRAMMED) // RL3
                            ? boot_start_i // RL1
                            : RESET_ADDR_APP; // RL1
        end
    end

endmodule : ivp_top

/* File: sim/ivp_core_model.sv */
// Behavioural core: takes offered vectors and retires instructions.
// Assumes the offer stands until acknowledged.
`timescale 1ns/1ps
module ivp_core_model
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    // Block side
    input  wire logic        irq_i,
    input  wire logic [15:0] vec_addr_i,
    input  wire logic        slow_i,
    output logic             vec_ack_o,
    output logic             insn_done_o,
    // Report to bench
    output logic             got_o,
    output logic [15:0]      got_addr_o
);
    logic [2:0] wait_cnt; // Cycles the offer stood
    // Ack at once or after five cycles, never twice
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            {vec_ack_o, insn_done_o, got_o, wait_cnt, got_addr_o} <= '0;
        end
        else
        begin
            insn_done_o <= !insn_done_o; // One instruction each two cycles
            vec_ack_o   <= 1'b0;
            got_o       <= 1'b0;
            if (vec_ack_o)
                wait_cnt <= 3'h0;
            else if (irq_i && wait_cnt == (slow_i ? 3'h5 : 3'h0))
            begin
                vec_ack_o  <= 1'b1;
                got_o      <= 1'b1;
                got_addr_o <= vec_addr_i; // Fetch only the offered slot
            end
            else if (irq_i)
                wait_cnt <= wait_cnt + 3'h1;
        end
    end
endmodule : ivp_core_model

/* File: sim/ivp_monitor.sv */
// Checker for the vector placement block, bound to its top module.
// Assumes one clock domain and the one-wait-state APB answer.
`timescale 1ns/1ps
module ivp_monitor
    import ivp_pkg::*;
(
    // Clock and reset
    input wire logic              core_clk_i,
    input wire logic              resetn_i,
    // APB
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic              pready_o,
    input wire logic [31:0]       prdata_o,
    input wire logic              pslverr_o,
    // Configuration and core side
    input wire logic              boot_reset_fuse_i,
    input wire logic [ADDR_W-1:0] boot_start_i,
    input wire logic              global_ie_i,
    input wire logic              vec_ack_i,
    input wire logic [ADDR_W-1:0] reset_addr_o,
    input wire logic              irq_o,
    input wire logic [ADDR_W-1:0] vec_addr_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // Offer still waiting, and offer being taken
    sequence s_wait; irq_o && !vec_ack_i; endsequence
    sequence s_take; irq_o && vec_ack_i; endsequence
    property p_hold; s_wait |=> irq_o && $stable(vec_addr_o); endproperty
    a_hold: assert property (p_hold) else $error("offer moved early");
    property p_take; s_take |=> !irq_o; endproperty
    a_take: assert property (p_take) else $error("offer kept after ack");
    // A launch needs the core's global flag
    property p_ie; $rose(irq_o) |-> $past(global_ie_i); endproperty
    a_ie: assert property (p_ie) else $error("launch with flag low");
    // Vector is an even slot of the table, at flash start or boot base
    property p_slot; irq_o |-> !vec_addr_o[0] && (vec_addr_o inside {[2:48]}
        || 16'(vec_addr_o - boot_start_i) inside {[2:48]}); endproperty
    a_slot: assert property (p_slot) else $error("vector off table");
    // Reset address follows the fuse level of the cycle before
    property p_rst; $past(resetn_i) |-> reset_addr_o ==
        ($past(boot_reset_fuse_i) ? 16'h0000 : $past(boot_start_i)); endproperty
    a_rst: assert property (p_rst) else $error("reset address wrong");
    // Register access: one wait state, one-cycle answer, zero data on writes
    property p_wait; psel_i && penable_i && !pready_o |=> pready_o; endproperty
    a_wait: assert property (p_wait) else $error("ready late");
    property p_one; pready_o |-> psel_i && penable_i ##1 !pready_o; endproperty
    a_one: assert property (p_one) else $error("ready not one cycle");
    property p_zero; pready_o && (pwrite_i || pslverr_o) |-> prdata_o == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("data on write");
endmodule : ivp_monitor

bind ivp_top ivp_monitor u_mon (.*);

/* File: sim/ivp_top_test.sv */
// Self-checking bench for the vector placement block.
// Assumes the core model in ivp_core_model and the bound checker.
`timescale 1ns/1ps
module ivp_top_test
    import ivp_pkg::*;
;
    logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
    logic        fuse = 1, ie = 1, slow = 0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, rdat, lf = 32'hb9e7;
    logic [15:0] boot = 16'h4c00, a;
    logic [23:0] req = '0, pend;
    wire         pready, pslverr, ack, done, irq, got;
    wire  [31:0] prdata;
    wire  [15:0] rst_addr, vaddr, got_addr;
    int          errors = 0, n_compared = 0;
    always #2 clk = ~clk; // 250 MHz
    ivp_top u_dut (.core_clk_i(clk), .resetn_i(rst_n), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
        .prdata_o(prdata), .pslverr_o(pslverr), .boot_reset_fuse_i(fuse),
        .boot_start_i(boot), .irq_req_i(req), .global_ie_i(ie), .insn_done_i(done),
        .vec_ack_i(ack), .reset_addr_o(rst_addr), .irq_o(irq), .vec_addr_o(vaddr));
    ivp_core_model u_core (.core_clk_i(clk), .resetn_i(rst_n), .irq_i(irq),
        .vec_addr_i(vaddr), .slow_i(slow), .vec_ack_o(ack), .insn_done_o(done),
        .got_o(got), .got_addr_o(got_addr));
    // Repeatable random values
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // Expected vector: slot 2*(i+1) at flash start or at boot base
    function automatic logic [15:0] exp_vec(input int i, input logic s);
        return (s ? boot : 16'h0) + 16'(2 * (i + 1));
    endfunction : exp_vec
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge clk);
        if (pready !== 1'b1)
        begin
            errors++;
            finish_test();
        end
        rdat = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
    endtask : apb
    // Wait until the core model has taken a vector
    task automatic take(output logic [15:0] v);
        int n;
        @(posedge clk);
        for (n = 0; n < 50 && got !== 1'b1; n++) @(posedge clk);
        if (got !== 1'b1)
        begin
            errors++;
            finish_test();
        end
        v = got_addr;
    endtask : take
    // Every source alone, prompt and slow acks alternating
    task automatic table_run(input logic s);
        for (int i = 0; i < NUM_SRC; i++)
        begin
            req <= 24'h1 << i;
            slow <= i[0];
            take(a);
            req <= '0;
            chk("vector", exp_vec(i, s), a);
            repeat (2) @(posedge clk);
        end
        $display("table test done");
    endtask : table_run
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        repeat (2) @(posedge clk);
        chk("reset_addr", 32'h0, rst_addr);
        fuse <= 0;
        repeat (3) @(posedge clk);
        chk("boot_addr", boot, rst_addr);
        fuse <= 1;
        apb(0, REG_ENABLE, 0);
        chk("enable_rst", ENABLE_RST, rdat);
        apb(0, REG_CTRL, 0);
        chk("ctrl_rst", {SEL_RST, 1'b0}, rdat);
        apb(0, 12'h010, 0);
        chk("unmapped", 1, err);
        $display("reset test done");
        apb(1, REG_ENABLE, 32'hffffff);
        table_run(0);
        // Guarded move to boot base, request pending
        apb(1, REG_CTRL, 32'h1);
        req <= 24'h8;
        apb(1, REG_CTRL, 32'h2);
        chk("blocked", 0, irq);
        take(a);
        req <= '0;
        chk("moved", exp_vec(3, 1), a);
        apb(0, REG_CTRL, 0);
        chk("sel_set", 32'h2, rdat);
        // Select write after the window is ignored
        apb(1, REG_CTRL, 32'h1);
        repeat (8) @(posedge clk);
        apb(1, REG_CTRL, 32'h0);
        apb(0, REG_CTRL, 0);
        chk("sel_kept", 32'h2, rdat);
        $display("change test done");
        table_run(1);
        // Disabled source or cleared flag offers nothing
        apb(1, REG_ENABLE, 32'hfffffe);
        req <= 24'h1;
        apb(0, REG_PEND, 0);
        chk("pend", 0, rdat);
        repeat (8) @(posedge clk);
        chk("no_irq_dis", 0, irq);
        ie <= 0;
        req <= 24'h2;
        repeat (8) @(posedge clk);
        chk("no_irq_ie", 0, irq);
        ie <= 1;
        take(a);
        req <= '0;
        chk("ie_back", exp_vec(1, 1), a);
        $display("refusal test done");
        // Random request sets served lowest slot first
        apb(1, REG_ENABLE, 32'hffffff);
        repeat (4)
        begin
            lf = lfsr(lf);
            pend = lf[23:0] | 24'h800000;
            req <= pend;
            slow <= lf[24];
            while (pend != 0)
            begin
                int k;
                k = 0;
                while (!pend[k]) k++;
                take(a);
                pend[k] = 1'b0;
                req <= pend;
                chk("prio", exp_vec(k, 1), a);
            end
            repeat (2) @(posedge clk);
        end
        $display("priority test done");
        finish_test();
    end
endmodule : ivp_top_test
